/* pkg/cdag_defs.svh */
// Constants for the cascaded DMA address generation pair.
// Assumes inclusion by bare name from the DMA end and host end modules.
`ifndef CDAG_DEFS_SVH
`define CDAG_DEFS_SVH

// IO decode bases (upper address bits)
`define CDAG_SLV_BASE      12'h000
`define CDAG_MST_BASE      11'h006
`define CDAG_PAGE_BASE     12'h008
// Controller register indices
`define CDAG_IDX_COMMAND   4'h8
`define CDAG_IDX_MODE      4'hB
`define CDAG_IDX_CLR_FF    4'hC
// Command and mode bit positions
`define CDAG_CMD_DISABLE   2
`define CDAG_CMD_ROTATE    4
`define CDAG_MODE_DEC      5
// Page store layout
`define CDAG_PAGE_DEPTH    16
`define CDAG_PG_CH0        4'h7
`define CDAG_PG_CH1        4'h3
`define CDAG_PG_CH2        4'h1
`define CDAG_PG_CH3        4'h2
`define CDAG_PG_CH5        4'hB
`define CDAG_PG_CH6        4'h9
`define CDAG_PG_CH7        4'hA
`define CDAG_PG_REFRESH    4'hF
// Controller clock division
`define CDAG_DIV_NORMAL    2
`define CDAG_DIV_TURBO     4
// Host IO strobe length in cycles
`define CDAG_IO_STROBE_CYC 3
`define CDAG_IO_CNT_W      2

`endif

/* pkg/cdag_pkg.sv */
// Types shared by both ends of the DMA address generation pair.
// Assumes nothing beyond a SystemVerilog compiler.
package cdag_pkg;

    typedef enum logic [3:0] {
        DEV_IDLE = 4'b0001,
        DEV_HOLD = 4'b0010,
        DEV_XFER = 4'b0100,
        DEV_DONE = 4'b1000
    } cdag_dev_state_type;

    typedef enum logic [2:0] {
        HST_IDLE   = 3'b001,
        HST_STROBE = 3'b010,
        HST_HELD   = 3'b100
    } cdag_hst_state_type;

endpackage

/* pkg/cdag_if.sv */
// Wires between the DMA pair and the host processor bus.
// Assumes both ends share one clock; the bench resolves any pin levels.
`timescale 1ns/1ps
interface cdag_if;
    logic [15:0] io_addr;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        io_write_strobe_n;
    logic        io_read_strobe_n;
    logic        hold_request_out;
    logic        hold_ack_in;
    logic [7:0]  dma_req;
    logic [7:0]  dma_ack;
    logic        refresh_cycle;
    logic [23:0] sys_addr;
    logic        sys_addr_lo_oe;
    logic        sys_addr_hi_oe;
    logic        byte_high_enable_n;
    logic        buffered_addr_latch_en;

    modport dev (
        input  io_addr, io_wdata, io_write_strobe_n, io_read_strobe_n,
        input  hold_ack_in, dma_req, refresh_cycle,
        output io_rdata, hold_request_out, dma_ack, sys_addr,
        output sys_addr_lo_oe, sys_addr_hi_oe, byte_high_enable_n,
        output buffered_addr_latch_en
    );

    modport host (
        output io_addr, io_wdata, io_write_strobe_n, io_read_strobe_n,
        output hold_ack_in, dma_req, refresh_cycle,
        input  io_rdata, hold_request_out, dma_ack, sys_addr,
        input  sys_addr_lo_oe, sys_addr_hi_oe, byte_high_enable_n,
        input  buffered_addr_latch_en
    );
endinterface

/* logic/cdag_dma_end.sv */
// Cascaded DMA pair: slave byte channels 0-3, master word channels 5-7,
// high-byte latches, page store and IO programming.
// Assumes IO strobes are synchronous to i_ref_clk and held low >= 2 cycles.
`timescale 1ns/1ps
`include "cdag_defs.svh"

// How it works
// - Slave hold request drives master cascade channel
// - Rotating priority drops last served channel lowest
// - Serviced cascade entry falls below channels 5-7
// - Bytes span 64 kB, words 128 kB
// - Page store holds sixteen entries, eight used
// - Page entry changes only on software write
// - Software loads base address and page first
// - First transfer latches high byte from current address
// - Address steps; latch reloads on carry/borrow only
// - Byte transfers: A0-A15 controller, A16-A23 page
// - Word transfers: A0 low, A1-A16, A17-A23 page
// - Byte high enable from A0 on byte transfers, low on word transfers; latch enable high
// - Software configures everything before requesting service
// - Software programs slave before master after power-up
// - Controller programming accepted only idle without hold acknowledge; page writes always
// - Idle controller samples its decoded chip select
// - Host never programs while hold acknowledge high
// - Slave decodes A0-A3, master A1-A4
// - Controllers clocked at half, quarter in turbo
module cdag_dma_end #(
    parameter int PAGE_DEPTH = `CDAG_PAGE_DEPTH
) (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst,
    // Host bus and peripherals
    cdag_if.dev             bus,
    // Mode and status
    input  wire logic       i_turbo_mode,
    output logic            o_dma_clk_en,
    output logic            o_busy,
    output logic [2:0]      o_active_channel
);

    if (PAGE_DEPTH != 16) begin : g_chk
        $error("PAGE_DEPTH must be 16");
    end

    function automatic logic [1:0] pick(input logic [3:0] req,
                                        input logic [1:0] last,
                                        input logic       rot);
        logic [1:0] s;
        logic [1:0] k;
        pick = 2'd0;
        s = rot ? 2'(last + 2'd1) : 2'd0;
        for (int i = 3; i >= 0; i--) begin
            k = 2'(s + 2'(i));
            if (req[k]) begin
                pick = k;
            end
        end
    endfunction

    function automatic logic [3:0] page_idx(input logic [2:0] ch);
        case (ch)
            3'd0:    page_idx = `CDAG_PG_CH0;
            3'd1:    page_idx = `CDAG_PG_CH1;
            3'd2:    page_idx = `CDAG_PG_CH2;
            3'd3:    page_idx = `CDAG_PG_CH3;
            3'd5:    page_idx = `CDAG_PG_CH5;
            3'd6:    page_idx = `CDAG_PG_CH6;
            3'd7:    page_idx = `CDAG_PG_CH7;
            default: page_idx = `CDAG_PG_REFRESH;
        endcase
    endfunction

    cdag_pkg::cdag_dev_state_type state_q;
    logic [1:0]  div_q;
    logic        wr_prev_q;
    logic        rd_prev_q;
    logic [15:0] cur_addr_q [8];
    logic [15:0] base_addr_q [8];
    logic [7:0]  dec_q;
    logic [7:0]  hi_pend_q;
    logic [7:0]  page_q [PAGE_DEPTH];
    logic [1:0]  rot_q;
    logic [1:0]  dis_q;
    logic [1:0]  ff_q;
    logic [1:0]  last_q [2];
    logic [7:0]  hi_latch_q [2];
    logic [2:0]  gnt_q;
    logic [23:0] addr_q;
    logic        bhe_n_q;
    logic [7:0]  rdata_q;

    // Controller clock enable
    wire         tick = i_turbo_mode ? (div_q == 2'd3) : div_q[0];

    // IO strobe edges and chip selects
    wire         wr_pulse = wr_prev_q & ~bus.io_write_strobe_n;
    wire         rd_pulse = rd_prev_q & ~bus.io_read_strobe_n;
    wire         sel_slv  = bus.io_addr[15:4] == `CDAG_SLV_BASE;
    wire         sel_mst  = bus.io_addr[15:5] == `CDAG_MST_BASE;
    wire         sel_page = bus.io_addr[15:4] == `CDAG_PAGE_BASE;
    wire         prog_ok  = (state_q == cdag_pkg::DEV_IDLE)
                            & ~bus.hold_ack_in;
    wire         ctl_sel  = (sel_slv | sel_mst) & prog_ok;
    wire         rc       = sel_mst;
    wire [3:0]   ridx     = sel_mst ? bus.io_addr[4:1]
                                    : bus.io_addr[3:0];
    wire [2:0]   rch      = {rc, ridx[2:1]};
    wire         is_addr  = ~ridx[3] & ~ridx[0];
    wire         ctl_wr   = wr_pulse & ctl_sel;
    wire         ctl_rd   = rd_pulse & ctl_sel;
    wire         addr_wr  = ctl_wr & is_addr & (rch != 3'd4);
    wire         mode_wr  = ctl_wr & (ridx == `CDAG_IDX_MODE);
    wire [2:0]   mode_ch  = {rc, bus.io_wdata[1:0]};
    wire         cmd_wr   = ctl_wr & (ridx == `CDAG_IDX_COMMAND);
    wire         clr_wr   = ctl_wr & (ridx == `CDAG_IDX_CLR_FF);
    wire         ff_step  = (ctl_wr | ctl_rd) & is_addr;
    wire         page_wr  = wr_pulse & sel_page;

    // Cascade and priority
    wire         slv_hrq  = |bus.dma_req[3:0] & ~dis_q[0];
    wire         casc_req = slv_hrq;
    wire [3:0]   mst_req  = {bus.dma_req[7:5], casc_req};
    wire         mst_hrq  = |mst_req & ~dis_q[1];
    wire [1:0]   mst_pick = pick(mst_req, last_q[1], rot_q[1]);
    wire [1:0]   slv_pick = pick(bus.dma_req[3:0], last_q[0], rot_q[0]);
    wire         casc_ack = (mst_pick == 2'd0);
    wire [2:0]   grant    = casc_ack ? {1'b0, slv_pick} : {1'b1, mst_pick};
    wire         do_grant = (state_q == cdag_pkg::DEV_HOLD)
                            & bus.hold_ack_in & tick;
    wire         do_step  = (state_q == cdag_pkg::DEV_XFER) & tick;

    // Address of the granted channel
    wire [15:0]  g_cur    = cur_addr_q[grant];
    wire         g_word   = grant[2];
    wire [7:0]   g_hi     = hi_pend_q[grant] ? g_cur[15:8]
                                             : hi_latch_q[g_word];
    wire [7:0]   g_page   = page_q[page_idx(grant)];
    wire [23:0]  g_addr   = g_word ? {g_page[7:1], g_hi, g_cur[7:0], 1'b0}
                                   : {g_page, g_hi, g_cur[7:0]};
    wire [15:0]  cur_g    = cur_addr_q[gnt_q];
    wire [15:0]  next_g   = dec_q[gnt_q] ? 16'(cur_g - 16'h0001)
                                         : 16'(cur_g + 16'h0001);
    wire         carry    = next_g[15:8] != cur_g[15:8];
    wire [7:0]   rd_val   = sel_page ? page_q[bus.io_addr[3:0]]
                          : ~(is_addr & ctl_sel) ? 8'h00
                          : ff_q[rc] ? cur_addr_q[rch][15:8]
                                     : cur_addr_q[rch][7:0];

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= cdag_pkg::DEV_IDLE;
        end else begin
            case (state_q)
                cdag_pkg::DEV_IDLE:
                    if (mst_hrq) state_q <= cdag_pkg::DEV_HOLD;
                cdag_pkg::DEV_HOLD:
                    if (~mst_hrq) state_q <= cdag_pkg::DEV_IDLE;
                    else if (do_grant) state_q <= cdag_pkg::DEV_XFER;
                cdag_pkg::DEV_XFER:
                    if (tick) state_q <= cdag_pkg::DEV_DONE;
                cdag_pkg::DEV_DONE:
                    if (tick) state_q <= cdag_pkg::DEV_IDLE;
                default: state_q <= cdag_pkg::DEV_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            div_q     <= 2'd0;
            wr_prev_q <= 1'b1;
            rd_prev_q <= 1'b1;
            rdata_q   <= 8'h00;
        end else begin
            div_q     <= 2'(div_q + 2'd1);
            wr_prev_q <= bus.io_write_strobe_n;
            rd_prev_q <= bus.io_read_strobe_n;
            if (rd_pulse) rdata_q <= rd_val;
        end
    end

    // Controller registers and channel addresses
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rot_q     <= 2'b00;
            dis_q     <= 2'b00;
            ff_q      <= 2'b00;
            dec_q     <= 8'h00;
            hi_pend_q <= 8'hFF;
            for (int i = 0; i < 8; i++) begin
                cur_addr_q[i]  <= 16'h0000;
                base_addr_q[i] <= 16'h0000;
            end
        end else begin
            if (cmd_wr) begin
                rot_q[rc] <= bus.io_wdata[`CDAG_CMD_ROTATE];
                dis_q[rc] <= bus.io_wdata[`CDAG_CMD_DISABLE];
            end
            if (mode_wr) dec_q[mode_ch] <= bus.io_wdata[`CDAG_MODE_DEC];
            if (clr_wr) ff_q[rc] <= 1'b0;
            else if (ff_step) ff_q[rc] <= ~ff_q[rc];
            if (addr_wr) begin
                hi_pend_q[rch] <= 1'b1;
                if (ff_q[rc]) begin
                    cur_addr_q[rch][15:8]  <= bus.io_wdata;
                    base_addr_q[rch][15:8] <= bus.io_wdata;
                end else begin
                    cur_addr_q[rch][7:0]  <= bus.io_wdata;
                    base_addr_q[rch][7:0] <= bus.io_wdata;
                end
            end
            if (do_grant) hi_pend_q[grant] <= 1'b0;
            if (do_step) begin
                cur_addr_q[gnt_q] <= next_g;
                if (carry) hi_pend_q[gnt_q] <= 1'b1;
            end
        end
    end

    // Page store, written only by software
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int i = 0; i < PAGE_DEPTH; i++) begin
                page_q[i] <= 8'h00;
            end
        end else if (page_wr) begin
            page_q[bus.io_addr[3:0]] <= bus.io_wdata;
        end
    end

    // Grant capture, latches and address outputs
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            gnt_q         <= 3'd0;
            addr_q        <= 24'h00_0000;
            bhe_n_q       <= 1'b1;
            hi_latch_q[0] <= 8'h00;
            hi_latch_q[1] <= 8'h00;
            last_q[0]     <= 2'd3;
            last_q[1]     <= 2'd3;
        end else if (do_grant) begin
            gnt_q              <= grant;
            addr_q             <= g_addr;
            bhe_n_q            <= g_word ? 1'b0 : ~g_cur[0];
            hi_latch_q[g_word] <= g_hi;
            last_q[1]          <= mst_pick;
            if (casc_ack) last_q[0] <= slv_pick;
        end else if (bus.refresh_cycle && state_q == cdag_pkg::DEV_IDLE) begin
            addr_q[23:16] <= page_q[`CDAG_PG_REFRESH];
        end
    end

    wire xfer = state_q == cdag_pkg::DEV_XFER;
    wire refr = bus.refresh_cycle & (state_q == cdag_pkg::DEV_IDLE);

    assign bus.hold_request_out       = state_q != cdag_pkg::DEV_IDLE;
    assign bus.dma_ack                = xfer ? 8'(1 << gnt_q) : 8'h00;
    assign bus.sys_addr               = addr_q;
    assign bus.sys_addr_lo_oe         = xfer;
    assign bus.sys_addr_hi_oe         = xfer | refr;
    assign bus.byte_high_enable_n     = xfer ? bhe_n_q : 1'b1;
    assign bus.buffered_addr_latch_en = xfer;
    assign bus.io_rdata               = rdata_q;
    assign o_dma_clk_en               = tick;
    assign o_busy                     = state_q != cdag_pkg::DEV_IDLE;
    assign o_active_channel           = gnt_q;

endmodule // cdag_dma_end

/* logic/cdag_host_end.sv */
// Host processor bus end: IO cycles to the DMA pair and hold handshake.
// Assumes user requests and peripheral requests are synchronous.
`timescale 1ns/1ps
`include "cdag_defs.svh"

module cdag_host_end (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    // DMA pair
    cdag_if.host             bus,
    // IO command port
    input  wire logic        i_cmd_valid,
    input  wire logic        i_cmd_write,
    input  wire logic [15:0] i_cmd_addr,
    input  wire logic [7:0]  i_cmd_wdata,
    output logic             o_cmd_ready,
    output logic             o_cmd_done,
    output logic [7:0]       o_cmd_rdata,
    // Peripherals and refresh
    input  wire logic [7:0]  i_dma_req,
    input  wire logic        i_refresh,
    output logic [7:0]       o_dma_ack,
    output logic [23:0]      o_dma_addr,
    output logic             o_dma_addr_valid,
    output logic             o_held
);

    cdag_pkg::cdag_hst_state_type state_q;
    logic [`CDAG_IO_CNT_W-1:0] cnt_q;
    logic                      write_q;
    logic [15:0]               addr_q;
    logic [7:0]                wdata_q;
    logic [7:0]                rdata_q;
    logic                      done_q;

    wire idle   = state_q == cdag_pkg::HST_IDLE;
    wire accept = idle & i_cmd_valid & ~bus.hold_request_out;
    wire last   = cnt_q == `CDAG_IO_CNT_W'(`CDAG_IO_STROBE_CYC - 1);

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= cdag_pkg::HST_IDLE;
        end else begin
            case (state_q)
                cdag_pkg::HST_IDLE:
                    if (accept) state_q <= cdag_pkg::HST_STROBE;
                    else if (bus.hold_request_out)
                        state_q <= cdag_pkg::HST_HELD;
                cdag_pkg::HST_STROBE:
                    if (last) state_q <= cdag_pkg::HST_IDLE;
                cdag_pkg::HST_HELD:
                    if (~bus.hold_request_out) state_q <= cdag_pkg::HST_IDLE;
                default: state_q <= cdag_pkg::HST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_q   <= '0;
            write_q <= 1'b0;
            addr_q  <= 16'h0000;
            wdata_q <= 8'h00;
            rdata_q <= 8'h00;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (accept) begin
                cnt_q   <= '0;
                write_q <= i_cmd_write;
                addr_q  <= i_cmd_addr;
                wdata_q <= i_cmd_wdata;
            end else if (state_q == cdag_pkg::HST_STROBE) begin
                cnt_q <= `CDAG_IO_CNT_W'(cnt_q + 1'b1);
                if (last) begin
                    done_q <= 1'b1;
                    if (~write_q) rdata_q <= bus.io_rdata;
                end
            end
        end
    end

    wire strobe = state_q == cdag_pkg::HST_STROBE;

    assign bus.io_addr           = addr_q;
    assign bus.io_wdata          = wdata_q;
    assign bus.io_write_strobe_n = ~(strobe & write_q);
    assign bus.io_read_strobe_n  = ~(strobe & ~write_q);
    assign bus.hold_ack_in       = state_q == cdag_pkg::HST_HELD;
    assign bus.dma_req           = i_dma_req;
    assign bus.refresh_cycle     = i_refresh;
    assign o_cmd_ready           = idle & ~bus.hold_request_out;
    assign o_cmd_done            = done_q;
    assign o_cmd_rdata           = rdata_q;
    assign o_dma_ack             = bus.dma_ack;
    assign o_dma_addr            = bus.sys_addr;
    assign o_dma_addr_valid      = bus.sys_addr_lo_oe;
    assign o_held                = state_q == cdag_pkg::HST_HELD;

endmodule // cdag_host_end

/* testbench/cdag_asserts.sv */
// Checker for the wires between the DMA pair and the host bus end.
// Assumes the bench instantiates it beside the interface, one clock.
`timescale 1ns/1ps
module cdag_asserts (
    // Clock and reset
    input wire logic        i_ref_clk,
    input wire logic        i_rst,
    // Host bus
    input wire logic        io_write_strobe_n,
    input wire logic        io_read_strobe_n,
    input wire logic        hold_request_out,
    input wire logic        hold_ack_in,
    // Transfer side
    input wire logic [7:0]  dma_ack,
    input wire logic [23:0] sys_addr,
    input wire logic        sys_addr_lo_oe,
    input wire logic        sys_addr_hi_oe,
    input wire logic        byte_high_enable_n,
    input wire logic        buffered_addr_latch_en
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    wire logic xfer_byte = sys_addr_lo_oe && (|dma_ack[3:0]);
    wire logic xfer_word = sys_addr_lo_oe && (|dma_ack[7:5]);

    property p_byte_bhe;
        xfer_byte |-> byte_high_enable_n == !sys_addr[0];
    endproperty
    a_byte_bhe: assert property (p_byte_bhe)
        else $error("byte high enable differs from inverted A0");
    property p_word_addr;
        xfer_word |-> !byte_high_enable_n && !sys_addr[0];
    endproperty
    a_word_addr: assert property (p_word_addr)
        else $error("word transfer with A0 or byte high enable high");
    property p_buffered_addr_latch_en;
        $rose(sys_addr_lo_oe) |-> buffered_addr_latch_en && sys_addr_hi_oe;
    endproperty
    a_buffered_addr_latch_en: assert property (p_buffered_addr_latch_en)
        else $error("latch enable or upper address not driven");
    property p_ack_hold;
        (|dma_ack) |-> hold_ack_in && sys_addr_lo_oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("acknowledge without hold acknowledge");
    property p_page_stable;
        sys_addr_lo_oe && $past(sys_addr_lo_oe) |-> $stable(sys_addr);
    endproperty
    a_page_stable: assert property (p_page_stable)
        else $error("address moved within one transfer");
    property p_strobe_len;
        $fell(io_write_strobe_n) |->
            !io_write_strobe_n [*3] ##1 io_write_strobe_n;
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("write strobe not low for three cycles");
    property p_no_prog_held;
        !(io_write_strobe_n && io_read_strobe_n) |-> !hold_ack_in;
    endproperty
    a_no_prog_held: assert property (p_no_prog_held)
        else $error("IO strobe while hold acknowledge high");
    property p_hold_resp;
        $rose(hold_request_out) |-> ##[1:8] hold_ack_in;
    endproperty
    a_hold_resp: assert property (p_hold_resp)
        else $error("hold request not acknowledged");
    property p_hold_release;
        $fell(hold_request_out) |-> ##1 !hold_ack_in;
    endproperty
    a_hold_release: assert property (p_hold_release)
        else $error("hold acknowledge kept after request dropped");
    property p_ack_len;
        $rose(|dma_ack) |-> (|dma_ack) [*2] ##[1:3] !(|dma_ack);
    endproperty
    a_ack_len: assert property (p_ack_len)
        else $error("acknowledge length not two or four cycles");

    c_byte: cover property (xfer_byte);
    c_word: cover property (xfer_word);
    c_refresh: cover property (sys_addr_hi_oe && !sys_addr_lo_oe);
endmodule // cdag_asserts

/* testbench/cascaded_dma_address_generation_bench.sv */
// Bench joining the DMA pair to the host bus end through the interface.
// Assumes the package, interface, design files and checker compile first.
`timescale 1ns/1ps
module cascaded_dma_address_generation_bench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        turbo = 1'b0;
    logic        cmd_valid = 1'b0;
    logic        cmd_write = 1'b0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [7:0]  cmd_wdata = 8'h00;
    logic [7:0]  dma_req = 8'h00;
    logic        refresh = 1'b0;
    logic        cmd_ready;
    logic        cmd_done;
    logic [7:0]  cmd_rdata;
    logic        clk_en;
    logic        busy;
    logic        held;
    logic [7:0]  rd;
    int          failures = 0;
    int          total_checks = 0;

    cdag_if bus_if ();
    cdag_dma_end cdag_dma_end_inst (
        .i_ref_clk(clk), .i_rst(rst), .bus(bus_if.dev),
        .i_turbo_mode(turbo), .o_dma_clk_en(clk_en), .o_busy(busy),
        .o_active_channel()
    );
    cdag_host_end cdag_host_end_inst (
        .i_ref_clk(clk), .i_rst(rst), .bus(bus_if.host),
        .i_cmd_valid(cmd_valid), .i_cmd_write(cmd_write),
        .i_cmd_addr(cmd_addr), .i_cmd_wdata(cmd_wdata),
        .o_cmd_ready(cmd_ready), .o_cmd_done(cmd_done),
        .o_cmd_rdata(cmd_rdata), .i_dma_req(dma_req),
        .i_refresh(refresh), .o_dma_ack(), .o_dma_addr(),
        .o_dma_addr_valid(), .o_held(held)
    );
    cdag_asserts cdag_asserts_inst (
        .i_ref_clk(clk), .i_rst(rst),
        .io_write_strobe_n(bus_if.io_write_strobe_n),
        .io_read_strobe_n(bus_if.io_read_strobe_n),
        .hold_request_out(bus_if.hold_request_out),
        .hold_ack_in(bus_if.hold_ack_in),
        .dma_ack(bus_if.dma_ack), .sys_addr(bus_if.sys_addr),
        .sys_addr_lo_oe(bus_if.sys_addr_lo_oe),
        .sys_addr_hi_oe(bus_if.sys_addr_hi_oe),
        .byte_high_enable_n(bus_if.byte_high_enable_n),
        .buffered_addr_latch_en(bus_if.buffered_addr_latch_en)
    );

    always #4 clk = ~clk;

    task automatic check_value(input string what, input logic [23:0] seen,
                               input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One IO cycle; valid held until the host end takes it
    task automatic io(input logic wr, input logic [15:0] a,
                      input logic [7:0] d);
        int n;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_addr <= a;
        cmd_wdata <= d;
        @(negedge clk);
        for (n = 0; n < 40 && cmd_ready !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'b0;
        for (n = 0; n < 10 && cmd_done !== 1'b1; n++) @(negedge clk);
        rd = cmd_rdata;
    endtask

    // Waits for one grant, judges it, then waits for the hold to end
    task automatic xfer(input logic [7:0] ack, input logic [23:0] a,
                        input logic chk_a, input logic last);
        int n;
        for (n = 0; n < 60 && bus_if.dma_ack === 8'h00; n++) @(negedge clk);
        check_value("grant", 24'(bus_if.dma_ack), 24'(ack));
        check_value("held", 24'({held, busy}), 24'h3);
        if (chk_a) begin
            check_value("address", bus_if.sys_addr, a);
            check_value("bhe", 24'(bus_if.byte_high_enable_n),
                        24'((|ack[3:0]) && !a[0]));
            check_value("ready", 24'(cmd_ready), 24'h0);
        end
        if (last) begin
            @(posedge clk);
            dma_req <= 8'h00;
        end
        for (n = 0; n < 20 && bus_if.dma_ack !== 8'h00; n++) @(negedge clk);
        for (n = 0; n < 20 && bus_if.hold_ack_in !== 1'b0; n++)
            @(negedge clk);
    endtask

    task automatic t_page();
        for (int i = 0; i < 16; i++) begin
            io(1'b1, 16'h0080 + 16'(i), 8'h40 + 8'(i));
        end
        for (int i = 0; i < 16; i++) begin
            io(1'b0, 16'h0080 + 16'(i), 8'h00);
            check_value("page", 24'(rd), 24'(8'h40 + 8'(i)));
        end
        $display("test page store done");
    endtask

    task automatic t_byte();
        io(1'b1, 16'h000c, 8'h00);
        io(1'b1, 16'h0004, 8'hff);
        io(1'b1, 16'h0004, 8'h12);
        @(posedge clk);
        dma_req <= 8'h04;
        xfer(8'h04, 24'h41_12ff, 1'b1, 1'b0);
        xfer(8'h04, 24'h41_1300, 1'b1, 1'b1);
        $display("test byte transfer done");
    endtask

    task automatic t_word();
        io(1'b1, 16'h00d8, 8'h00);
        io(1'b1, 16'h00c4, 8'h00);
        io(1'b1, 16'h00c4, 8'h80);
        io(1'b1, 16'h00d6, 8'h21);
        @(posedge clk);
        dma_req <= 8'h20;
        xfer(8'h20, 24'h4b_0000, 1'b1, 1'b0);
        xfer(8'h20, 24'h4a_fffe, 1'b1, 1'b1);
        io(1'b1, 16'h00d8, 8'h00);
        io(1'b0, 16'h00c4, 8'h00);
        check_value("addr low", 24'(rd), 24'h00_00fe);
        io(1'b0, 16'h00c4, 8'h00);
        check_value("addr high", 24'(rd), 24'h00_007f);
        io(1'b0, 16'h0054, 8'h00);
        check_value("unmapped", 24'(rd), 24'h00_0000);
        $display("test word transfer done");
    endtask

    task automatic t_disable();
        io(1'b1, 16'h0008, 8'h04);
        @(posedge clk);
        dma_req <= 8'h01;
        repeat (20) @(negedge clk);
        check_value("no hold", 24'(bus_if.hold_request_out),
                    24'h0);
        io(1'b1, 16'h0008, 8'h00);
        xfer(8'h01, 24'h47_0000, 1'b1, 1'b1);
        $display("test disable done");
    endtask

    task automatic t_rotate();
        io(1'b1, 16'h00d0, 8'h10);
        @(posedge clk);
        dma_req <= 8'h2a;
        xfer(8'h20, 24'h00_0000, 1'b0, 1'b0);
        xfer(8'h02, 24'h00_0000, 1'b0, 1'b0);
        xfer(8'h20, 24'h00_0000, 1'b0, 1'b0);
        xfer(8'h02, 24'h00_0000, 1'b0, 1'b1);
        $display("test rotation done");
    endtask

    task automatic t_refresh();
        @(posedge clk);
        refresh <= 1'b1;
        repeat (3) @(negedge clk);
        check_value("refresh page", 24'(bus_if.sys_addr[23:16]),
                    24'h4f);
        check_value("refresh oe", 24'(bus_if.sys_addr_hi_oe),
                    24'h1);
        @(posedge clk);
        refresh <= 1'b0;
        $display("test refresh done");
    endtask

    task automatic t_clock(input logic fast, input int exp);
        int cnt;
        cnt = 0;
        @(posedge clk);
        turbo <= fast;
        repeat (8) @(negedge clk);
        repeat (16) begin
            @(negedge clk);
            cnt += (clk_en === 1'b1);
        end
        check_value("clock enables", 24'(cnt), 24'(exp));
        $display("test clock division done");
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        t_page();
        t_byte();
        t_word();
        t_disable();
        t_rotate();
        t_refresh();
        t_clock(1'b0, 8);
        t_clock(1'b1, 4);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end
endmodule // cascaded_dma_address_generation_bench
